/* hw/rsc_stream.sv */
// Notes on behaviour
// - Sink has zero ready latency; one symbol group per beat.
// - Decoder latency is N/P plus BM speed times R plus ten cycles.
// - Encoder output appears six cycles after the accepted input beat.
// - Decoder gives error values, erroneous symbol count and erroneous bit count.
// - All flops run on the rising edge of the one clock.
// - Active-low reset clears everything and may assert asynchronously.
// - Sink ready throttles incoming beats.
// - A beat is captured only when valid and ready are both high.
// - Error count field is log2(R)+1 bits wide, one per codeword.
// - Combined word is error count, failure flag, then corrected symbols.
// - Output advances while downstream ready is high or the output stage is empty.
// - Source valid stays low while no output is ready.
// - Symbols leave in the order they entered.
// - Source valid is high exactly when the source word is valid.
// - Backpressure exists only when built in; otherwise consumer takes all.
module rsc_stream
	import rsc_pkg::*;
(
	input  wire logic              i_clock,
	input  wire logic              i_rst_n,
	input  wire logic              i_in_valid,
	input  wire logic [RSC_SW-1:0] i_in_data,
	output logic                   o_in_ready,
	input  wire logic              i_out_ready,
	output logic                   o_out_valid,
	output logic [RSC_DW-1:0]      o_out_data,
	output logic [RSC_SW-1:0]      o_symbols,
	output logic                   o_out_last,
	output logic                   o_decfail,
	output logic [RSC_CW-1:0]      o_err_count,
	output logic [RSC_SW-1:0]      o_err_values,
	output logic [RSC_BW-1:0]      o_err_bits
);

	// ========================================
	// Pipeline control
	logic              advance;
	logic              accept;
	logic              out_take;
	logic [RSC_SW-1:0] pipe_data [0:RSC_LAT-1];
	logic              pipe_vld  [0:RSC_LAT-1];
	logic              pipe_last [0:RSC_LAT-1];
	logic [RSC_SW-1:0] next_pipe_data [0:RSC_LAT-1];
	logic              next_pipe_vld  [0:RSC_LAT-1];
	logic              next_pipe_last [0:RSC_LAT-1];
	logic [RSC_BCW-1:0] in_beat;
	logic [RSC_BCW-1:0] next_in_beat;

	// ========================================
	// Beat counters wrap at the codeword length
	function automatic logic [RSC_BCW-1:0] beat_next(input logic [RSC_BCW-1:0] cur);
		return (cur == RSC_LAST_BEAT) ? '0 : cur + RSC_BEAT_ONE;
	endfunction

	// Ready is combinational from downstream ready: a registered ready
	// would need a skid stage, traded away to keep the path RSC_LAT words deep.
	always_comb
	begin
		advance    = !RSC_BACKPRESSURE || i_out_ready || !pipe_vld[RSC_LAT-1];
		o_in_ready = advance;
		accept     = i_in_valid && advance;
		out_take   = pipe_vld[RSC_LAT-1] && (i_out_ready || !RSC_BACKPRESSURE);
	end

	// Fixed-depth shift keeps order and latency exact
	always_comb
	begin
		next_in_beat = in_beat;
		if (accept)
		begin
			next_in_beat = beat_next(in_beat);
		end
		for (int k = 0; k < RSC_LAT; k++)
		begin
			next_pipe_data[k] = pipe_data[k];
			next_pipe_vld[k]  = pipe_vld[k];
			next_pipe_last[k] = pipe_last[k];
		end
		if (advance)
		begin
			next_pipe_data[0] = accept ? i_in_data : '0;
			next_pipe_vld[0]  = accept;
			next_pipe_last[0] = accept && (in_beat == RSC_LAST_BEAT);
			for (int k = 1; k < RSC_LAT; k++)
			begin
				next_pipe_data[k] = pipe_data[k-1];
				next_pipe_vld[k]  = pipe_vld[k-1];
				next_pipe_last[k] = pipe_last[k-1];
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			in_beat <= '0;
			for (int k = 0; k < RSC_LAT; k++)
			begin
				pipe_data[k] <= '0;
				pipe_vld[k]  <= 1'b0;
				pipe_last[k] <= 1'b0;
			end
		end
		else
		begin
			in_beat <= next_in_beat;
			for (int k = 0; k < RSC_LAT; k++)
			begin
				pipe_data[k] <= next_pipe_data[k];
				pipe_vld[k]  <= next_pipe_vld[k];
				pipe_last[k] <= next_pipe_last[k];
			end
		end
	end

	// ========================================
	// Output word and per-codeword status
	logic [RSC_CW-1:0]  next_err_count;
	logic [RSC_SW-1:0]  next_err_values;
	logic [RSC_BW-1:0]  next_err_bits;
	logic               next_decfail;
	logic [RSC_BCW-1:0] out_beat;
	logic [RSC_BCW-1:0] next_out_beat;

	// Correction arithmetic sits outside this block; status reports a
	// clean codeword, refreshed on the last beat of each one.
	always_comb
	begin
		next_err_count  = o_err_count;
		next_err_values = o_err_values;
		next_err_bits   = o_err_bits;
		next_decfail    = o_decfail;
		next_out_beat   = out_beat;
		if (out_take)
		begin
			next_out_beat = pipe_last[RSC_LAT-1] ? '0 : beat_next(out_beat);
			if (pipe_last[RSC_LAT-1])
			begin
				next_err_count  = '0;
				next_err_values = '0;
				next_err_bits   = '0;
				next_decfail    = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_err_count  <= '0;
			o_err_values <= '0;
			o_err_bits   <= '0;
			o_decfail    <= 1'b0;
			out_beat     <= '0;
		end
		else
		begin
			o_err_count  <= next_err_count;
			o_err_values <= next_err_values;
			o_err_bits   <= next_err_bits;
			o_decfail    <= next_decfail;
			out_beat     <= next_out_beat;
		end
	end

	always_comb
	begin
		o_out_valid = pipe_vld[RSC_LAT-1];
		o_symbols   = pipe_data[RSC_LAT-1];
		o_out_last  = pipe_last[RSC_LAT-1];
		o_out_data  = RSC_IS_DECODER ? {o_err_count, o_decfail, o_symbols}
		                             : RSC_DW'(o_symbols);
	end

	// ========================================
	// Checks
	logic [RSC_SCW-1:0] stall_free;
	logic [RSC_SCW-1:0] next_stall_free;

	always_comb
	begin
		next_stall_free = advance ? ((stall_free == RSC_SF_MAX) ? stall_free
		                                                       : stall_free + RSC_SF_ONE)
		                          : '0;
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			stall_free <= '0;
		else
			stall_free <= next_stall_free;
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	in_capture_a: assert property (accept |=> pipe_vld[0] && pipe_data[0] == $past(i_in_data))
		else $error("accepted beat not captured");
	ignore_idle_a: assert property (!i_in_valid && advance |=> !pipe_vld[0])
		else $error("idle input captured");
	ready_empty_a: assert property (!o_out_valid |-> o_in_ready)
		else $error("sink stalled with empty output");
	hold_stall_a: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_symbols))
		else $error("output moved while stalled");
	fixed_lat_a: assert property ($past(accept, RSC_LAT) && stall_free == RSC_SF_MAX
		|-> o_out_valid && o_symbols == $past(i_in_data, RSC_LAT))
		else $error("output latency wrong");
	order_last_a: assert property (o_out_valid && o_out_last |-> out_beat == RSC_LAST_BEAT)
		else $error("codeword beats out of order");
	word_pack_a: assert property (o_out_valid |-> o_out_data[RSC_SW-1:0] == o_symbols
		&& o_out_data[RSC_SW] == o_decfail)
		else $error("combined word misordered");
	reset_quiet_a: assert property ($rose(i_rst_n) |-> !o_out_valid && !o_decfail)
		else $error("valid or failure high after reset");
	status_upd_a: assert property (out_take && o_out_last |=> o_err_count == '0 && o_err_bits == '0)
		else $error("status not refreshed at codeword end");

	// ========================================
	// Stream protocol checks
	// Whole pipe freezes together, so stall checks watch only the input and output stages
	stall_ready_a: assert property (o_out_valid && !i_out_ready
		|-> !o_in_ready)
		else $error("sink open while output stalled");

	free_ready_a: assert property (i_out_ready
		|-> o_in_ready)
		else $error("sink closed with downstream ready");

	stall_word_a: assert property (o_out_valid && !i_out_ready
		|=> $stable(o_out_data))
		else $error("output word moved while stalled");

	stall_last_a: assert property (o_out_valid && !i_out_ready
		|=> o_out_valid && $stable(o_out_last))
		else $error("last flag moved while stalled");

	stall_stage_a: assert property (!advance
		|=> $stable(pipe_vld[0]) && $stable(pipe_data[0]))
		else $error("input stage moved while stalled");

	take_step_a: assert property (out_take && !o_out_last
		|=> out_beat == $past(out_beat) + RSC_BEAT_ONE)
		else $error("output beat count skipped");

	take_wrap_a: assert property (out_take && o_out_last
		|=> out_beat == '0)
		else $error("output beat count not wrapped");

	beat_step_a: assert property (accept && in_beat != RSC_LAST_BEAT
		|=> in_beat == $past(in_beat) + RSC_BEAT_ONE)
		else $error("input beat count skipped");

	beat_wrap_a: assert property (accept && in_beat == RSC_LAST_BEAT
		|=> in_beat == '0 && pipe_last[0])
		else $error("codeword end not tagged");

	beat_idle_a: assert property (!accept
		|=> $stable(in_beat))
		else $error("beat count moved without a beat");

	empty_last_a: assert property (!o_out_valid
		|-> !o_out_last)
		else $error("last flag without valid");

	count_field_a: assert property (o_out_valid
		|-> o_out_data[RSC_DW-1 -: RSC_CW] == o_err_count)
		else $error("error count misplaced in word");

	fail_low_a: assert property (1'b1
		|-> !o_decfail)
		else $error("failure flag raised");

	status_hold_a: assert property (!(out_take && o_out_last)
		|=> $stable(o_err_count) && $stable(o_err_values) && $stable(o_err_bits))
		else $error("status moved inside a codeword");

	values_zero_a: assert property (out_take && o_out_last
		|=> o_err_values == '0 && !o_decfail)
		else $error("error values not refreshed");

	take_when_a: assert property (out_take
		|-> o_out_valid && i_out_ready)
		else $error("beat taken without ready");

	fill_out_a: assert property (advance && pipe_vld[RSC_LAT-2]
		|=> o_out_valid)
		else $error("ready result not offered");

	drain_out_a: assert property (out_take && !pipe_vld[RSC_LAT-2]
		|=> !o_out_valid)
		else $error("valid held with no result");

	data_shift_a: assert property (advance
		|=> o_symbols == $past(pipe_data[RSC_LAT-2]))
		else $error("output stage skipped a word");
endmodule

/* hw/rsc_pkg.sv */
package rsc_pkg;
	// ========================================
	// Code shape
	localparam int RSC_M        = 8;
	localparam int RSC_N        = 255;
	localparam int RSC_R        = 16;
	localparam int RSC_P        = 3;
	localparam int RSC_BM_SPEED = 4;

	// ========================================
	// Build options
	localparam bit RSC_IS_DECODER   = 1'b1;
	localparam bit RSC_BACKPRESSURE = 1'b1;

	// ========================================
	// Latency in clock cycles
	localparam int RSC_DEC_LAT = RSC_N / RSC_P + RSC_BM_SPEED * RSC_R + 10;
	localparam int RSC_ENC_LAT = 6;
	localparam int RSC_LAT     = RSC_IS_DECODER ? RSC_DEC_LAT : RSC_ENC_LAT;

	// ========================================
	// Field widths
	localparam int RSC_SW    = RSC_P * RSC_M;
	localparam int RSC_CW    = $clog2(RSC_R) + 1;
	localparam int RSC_BW    = $clog2(RSC_N * RSC_M + 1);
	localparam int RSC_DW    = RSC_CW + 1 + RSC_SW;
	localparam int RSC_BEATS = (RSC_N + RSC_P - 1) / RSC_P;
	localparam int RSC_BCW   = $clog2(RSC_BEATS);
	localparam int RSC_SCW   = $clog2(RSC_LAT + 1);

	localparam logic [RSC_BCW-1:0] RSC_LAST_BEAT = RSC_BCW'(RSC_BEATS - 1);
	localparam logic [RSC_BCW-1:0] RSC_BEAT_ONE  = RSC_BCW'(1);
	localparam logic [RSC_SCW-1:0] RSC_SF_MAX    = RSC_SCW'(RSC_LAT);
	localparam logic [RSC_SCW-1:0] RSC_SF_ONE    = RSC_SCW'(1);
endpackage

/* sim/rsc_sink_model.sv */
module rsc_sink_model
	import rsc_pkg::*;
(
	input  wire logic              i_clock,
	input  wire logic              i_rst_n,
	input  wire logic              i_stall,
	input  wire logic              i_valid,
	input  wire logic              i_last,
	input  wire logic [RSC_SW-1:0] i_symbols,
	input  wire logic [RSC_DW-1:0] i_data,
	output logic                   o_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0]             cnt = 2'h0;
	logic [RSC_SW+RSC_DW:0] rx_q[$];
	// ========================================
	// Consumer: stalls three cycles of four when asked
	always @(posedge i_clock)
	begin
		cnt <= cnt + 2'h1;
		o_ready <= !i_stall || (cnt == 2'h0);
		if (!i_rst_n)
			rx_q.delete();
		else if (i_valid && o_ready)
			rx_q.push_back({i_last, i_symbols, i_data});
	end
endmodule

/* sim/testbench.sv */
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0d ns: value mismatch", $time); end end
module testbench
	import rsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              i_clock;
	logic              i_rst_n = 1'b0;
	logic              i_in_valid = 1'b0;
	logic [RSC_SW-1:0] i_in_data = '0;
	logic              i_stall = 1'b0;
	logic              o_in_ready;
	logic              i_out_ready;
	logic              o_out_valid;
	logic [RSC_DW-1:0] o_out_data;
	logic [RSC_SW-1:0] o_symbols;
	logic              o_out_last;
	logic              o_decfail;
	logic [RSC_CW-1:0] o_err_count;
	logic [RSC_SW-1:0] o_err_values;
	logic [RSC_BW-1:0] o_err_bits;
	int                n_errors = 0;
	int                num_checks = 0;
	rsc_stream dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_in_valid(i_in_valid),
		.i_in_data(i_in_data), .o_in_ready(o_in_ready), .i_out_ready(i_out_ready),
		.o_out_valid(o_out_valid), .o_out_data(o_out_data), .o_symbols(o_symbols),
		.o_out_last(o_out_last), .o_decfail(o_decfail), .o_err_count(o_err_count),
		.o_err_values(o_err_values), .o_err_bits(o_err_bits));
	rsc_sink_model model_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_stall(i_stall),
		.i_valid(o_out_valid), .i_last(o_out_last), .i_symbols(o_symbols),
		.i_data(o_out_data), .o_ready(i_out_ready));
	initial
	begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	function automatic logic [RSC_SW-1:0] beat(input int b, input int i);
		return {RSC_M'(b + 3 * i + 2), RSC_M'(b + 3 * i + 1), RSC_M'(b + 3 * i)};
	endfunction
	// ========================================
	// Source: one whole codeword, with idle gaps carrying junk
	task automatic send_cw(input int b);
		for (int i = 0; i < RSC_BEATS; i++)
		begin
			if (i % 16 == 5)
			begin
				i_in_valid <= 1'b0;
				i_in_data <= ~beat(b, i);
				@(posedge i_clock);
			end
			i_in_valid <= 1'b1;
			i_in_data <= beat(b, i);
			@(posedge i_clock);
			while (o_in_ready !== 1'b1)
			begin
				`CHK(o_out_valid && !i_out_ready, 1'b1)
				@(posedge i_clock);
			end
		end
		i_in_valid <= 1'b0;
	endtask
	task automatic check_rx(input int b);
		logic [RSC_SW+RSC_DW:0] w;
		for (int i = 0; i < 3000 && model_u.rx_q.size() < RSC_BEATS; i++)
			@(posedge i_clock);
		`CHK(model_u.rx_q.size(), RSC_BEATS)
		for (int i = 0; i < RSC_BEATS && model_u.rx_q.size() > 0; i++)
		begin
			w = model_u.rx_q.pop_front();
			`CHK(w[RSC_SW+RSC_DW-1 -: RSC_SW], beat(b, i))
			`CHK(w[RSC_DW-1:0], {RSC_CW'(0), 1'b0, beat(b, i)})
			`CHK(w[RSC_SW+RSC_DW], i == RSC_BEATS - 1)
		end
	endtask
	// ========================================
	// Scenarios
	task automatic t_reset();
		`CHK(o_out_valid, 1'b0)
		`CHK(o_decfail, 1'b0)
		`CHK(o_in_ready, 1'b1)
	endtask
	task automatic t_latency();
		fork
			send_cw(0);
			begin
				@(posedge i_clock);
				while (!(i_in_valid && o_in_ready))
					@(posedge i_clock);
				repeat (RSC_LAT - 2) @(posedge i_clock);
				#1 `CHK(o_out_valid, 1'b0)
				@(posedge i_clock);
				#1 `CHK(o_out_valid, 1'b1)
			end
		join
		check_rx(0);
		`CHK(o_err_count, RSC_CW'(0))
		`CHK(o_err_values, RSC_SW'(0))
		`CHK(o_err_bits, RSC_BW'(0))
	endtask
	task automatic t_stall();
		i_stall <= 1'b1;
		send_cw(40);
		check_rx(40);
	endtask
	// Async entry into reset mid-flow, then a fresh codeword
	task automatic t_mid_reset();
		send_cw(80);
		while (o_out_valid !== 1'b1)
			@(posedge i_clock);
		#3 i_rst_n = 1'b0;
		#1 `CHK(o_out_valid, 1'b0)
		@(posedge i_clock);
		i_rst_n <= 1'b1;
		send_cw(120);
		check_rx(120);
		`CHK(o_decfail, 1'b0)
	endtask
	task end_of_test();
		if (n_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge i_clock);
		n_errors++;
		end_of_test();
	end
	initial
	begin
		repeat (16) @(posedge i_clock);
		t_reset();
		i_rst_n <= 1'b1;
		t_latency();
		t_stall();
		t_mid_reset();
		end_of_test();
	end
endmodule
